/* File: rtl/ipts_map.vh */
`ifndef IPTS_MAP_VH
`define IPTS_MAP_VH

// register byte offsets
`define IPTS_OFF_PRI_LO 8'h40
`define IPTS_OFF_PRI_HI 8'h41
`define IPTS_OFF_SEC_LO 8'h42
`define IPTS_OFF_SEC_HI 8'h43
`define IPTS_OFF_SLAVE 8'h44

// reset values
`define IPTS_RST_CHAN 16'h0000
`define IPTS_RST_SLAVE 8'h00

// reserved bits 11:10 of the channel timing register read zero
`define IPTS_CHAN_MASK 16'hF3FF

// channel timing register field positions
`define IPTS_F_FAST0 0
`define IPTS_F_RDY0 1
`define IPTS_F_POST0 2
`define IPTS_F_DMA0 3
`define IPTS_F_FAST1 4
`define IPTS_F_RDY1 5
`define IPTS_F_POST1 6
`define IPTS_F_DMA1 7
`define IPTS_F_RCT_LO 8
`define IPTS_F_ISP_LO 12
`define IPTS_F_SEPSEL 14

// slave timing register field positions (low bit of each pair)
`define IPTS_F_PRI_RCT1 0
`define IPTS_F_PRI_ISP1 2
`define IPTS_F_SEC_RCT1 4
`define IPTS_F_SEC_ISP1 6

// timing counts in clocks
`define IPTS_ISP_00 3'h5
`define IPTS_ISP_01 3'h4
`define IPTS_ISP_10 3'h3
`define IPTS_RCT_00 3'h4
`define IPTS_RCT_01 3'h3
`define IPTS_RCT_10 3'h2
`define IPTS_RCT_11 3'h1
`define IPTS_COMPAT_ISP 3'h7
`define IPTS_COMPAT_RCT 3'h7

`endif

/* File: rtl/ipts_engine.v */
`timescale 1ns/1ps
`default_nettype none

module ipts_engine (
  input wire clk_i, // clock
  input wire srst_i, // sync reset, high
  input wire req_i, // access request, taken while idle
  input wire write_i, // 1 = write strobe
  input wire [2:0] sample_i, // clocks from strobe to first ready sample
  input wire [2:0] recov_i, // min clocks from last sample to next strobe
  input wire ready_en_i, // honour ready line
  input wire post_i, // prefetch/posting allowed
  input wire iordy_i, // synchronised ready line
  output reg rd_n_o, // read strobe, low active
  output reg wr_n_o, // write strobe, low active
  output reg ack_o, // one-cycle completion pulse
  output reg prefetch_o, // current read is a prefetch
  output wire busy_o // engine not idle
);

  localparam ST_IDLE = 3'b001;
  localparam ST_STB = 3'b010;
  localparam ST_REC = 3'b100;

  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [2:0] rec_q;
  reg posted_q;
  reg rdy_en_q;

  assign busy_o = (state_q != ST_IDLE);

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      rec_q <= 3'h0;
      posted_q <= 1'b0;
      rdy_en_q <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      ack_o <= 1'b0;
      prefetch_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_i) begin
            state_q <= ST_STB;
            // timing is frozen per access so a register write mid-cycle
            // cannot stretch or cut a strobe already on the cable
            cnt_q <= sample_i - 3'h1;
            rec_q <= recov_i;
            rdy_en_q <= ready_en_i;
            posted_q <= post_i & write_i;
            prefetch_o <= post_i & ~write_i;
            ack_o <= post_i & write_i;
            rd_n_o <= write_i;
            wr_n_o <= ~write_i;
          end
        end
        ST_STB: begin
          if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
          end else if (!rdy_en_q || iordy_i) begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            cnt_q <= rec_q - 3'h1;
            ack_o <= ~posted_q;
            state_q <= ST_REC;
          end
        end
        ST_REC: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          rd_n_o <= 1'b1;
          wr_n_o <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: rtl/ipts_top.v */
// Notes on behaviour
// - drive 1 with fast bank clear uses compatible timing, except dma accesses while its dma fast enable bit is one
// - drive 1 fast, separate select clear: shared sample and recovery fields
// - drive 1 fast, separate select set: slave register fields of channel
// - drive 0 dma fast enable: fast only for dma, pio stays compatible
// - drive 0 prefetch and posting only while its enable bit is one
// - drive 0 ready line sampled only while its enable bit is one
// - drive 0 fast bank: clear compatible, set shared sample and recovery; dma fast enable makes dma fast and pio compatible whatever the bank bit
// - secondary drive 1 sample point 5, 4, 3 clocks; code 11 reserved
// - secondary drive 1 recovery 4, 3, 2, 1 clocks for codes 00 to 11
// - primary drive 1 sample point 5, 4, 3 clocks; code 11 reserved
// - primary drive 1 recovery 4, 3, 2, 1 clocks for codes 00 to 11
// - slave timing register read/write, resets to zero, pata only
// - separate select: clear shared for both, set slave for drive 1
// - shared sample point 5, 4, 3 clocks; code 11 reserved
// - shared recovery 4, 3, 2, 1 clocks for codes 00 to 11
`timescale 1ns/1ps
`default_nettype none
`include "ipts_map.vh"

module ipts_top (
  input wire clk_i, // 10 MHz clock
  input wire srst_i, // sync reset, high
  input wire [7:0] cfg_addr_i, // config byte address
  input wire cfg_wr_i, // config byte write strobe
  input wire cfg_rd_i, // config byte read strobe
  input wire [7:0] cfg_wdata_i, // config write data
  output reg [7:0] cfg_rdata_o, // config read data, valid after cfg_rd_i
  input wire [1:0] acc_req_i, // per channel data-port access request
  input wire [1:0] acc_drive1_i, // per channel target is drive 1
  input wire [1:0] acc_dma_i, // per channel access is dma
  input wire [1:0] acc_write_i, // per channel access is a write
  input wire [1:0] iordy_i, // per channel ready pin, asynchronous
  output wire [1:0] dior_n_o, // per channel read strobe, low active
  output wire [1:0] diow_n_o, // per channel write strobe, low active
  output wire [1:0] acc_ack_o, // per channel completion pulse
  output wire [1:0] acc_busy_o, // per channel engine busy
  output wire [1:0] prefetch_o // per channel current read is prefetch
);

  reg [15:0] chan_q [0:1];
  reg [7:0] slave_q;
  reg [1:0] rdy_meta_q;
  reg [1:0] rdy_sync_q;
  wire [4:0] cfg_hit;
  localparam [15:0] CHAN_MASK = `IPTS_CHAN_MASK;

  // sample point code to clocks; reserved 11 falls back to the
  // shortest legal setting rather than an undefined strobe
  function [2:0] isp_clks;
    input [1:0] code;
    begin
      case (code)
        2'h0: isp_clks = `IPTS_ISP_00;
        2'h1: isp_clks = `IPTS_ISP_01;
        default: isp_clks = `IPTS_ISP_10;
      endcase
    end
  endfunction

  function [2:0] rct_clks;
    input [1:0] code;
    begin
      case (code)
        2'h0: rct_clks = `IPTS_RCT_00;
        2'h1: rct_clks = `IPTS_RCT_01;
        2'h2: rct_clks = `IPTS_RCT_10;
        default: rct_clks = `IPTS_RCT_11;
      endcase
    end
  endfunction

  // fast timing qualifier: dma-only enable keeps pio compatible
  function fast_sel;
    input bank;
    input dma_only;
    input is_dma;
    begin
      fast_sel = is_dma ? (bank | dma_only) : (bank & ~dma_only);
    end
  endfunction

  // drive 1 slave fields: primary channel in bits 3:0, secondary in 7:4
  function [1:0] slv_field;
    input [7:0] slv;
    input chan;
    input is_isp;
    begin
      case ({chan, is_isp})
        2'h0: slv_field = slv[`IPTS_F_PRI_RCT1 +: 2];
        2'h1: slv_field = slv[`IPTS_F_PRI_ISP1 +: 2];
        2'h2: slv_field = slv[`IPTS_F_SEC_RCT1 +: 2];
        default: slv_field = slv[`IPTS_F_SEC_ISP1 +: 2];
      endcase
    end
  endfunction

  // one byte lane per mapped address, shared by the write and read paths
  function [4:0] cfg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `IPTS_OFF_PRI_LO: cfg_sel = 5'h01;
        `IPTS_OFF_PRI_HI: cfg_sel = 5'h02;
        `IPTS_OFF_SEC_LO: cfg_sel = 5'h04;
        `IPTS_OFF_SEC_HI: cfg_sel = 5'h08;
        `IPTS_OFF_SLAVE: cfg_sel = 5'h10;
        default: cfg_sel = 5'h00;
      endcase
    end
  endfunction

  assign cfg_hit = cfg_sel(cfg_addr_i);

  // reserved bits 11:10 are dropped on the way in so they always read zero
  always @(posedge clk_i) begin
    if (srst_i) begin
      chan_q[0] <= `IPTS_RST_CHAN;
      chan_q[1] <= `IPTS_RST_CHAN;
      slave_q <= `IPTS_RST_SLAVE;
    end else if (cfg_wr_i) begin
      if (cfg_hit[0]) begin
        chan_q[0][7:0] <= cfg_wdata_i;
      end
      if (cfg_hit[1]) begin
        chan_q[0][15:8] <= cfg_wdata_i & CHAN_MASK[15:8];
      end
      if (cfg_hit[2]) begin
        chan_q[1][7:0] <= cfg_wdata_i;
      end
      if (cfg_hit[3]) begin
        chan_q[1][15:8] <= cfg_wdata_i & CHAN_MASK[15:8];
      end
      if (cfg_hit[4]) begin
        slave_q <= cfg_wdata_i;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (cfg_rd_i) begin
      case (cfg_hit)
        5'h01: cfg_rdata_o <= chan_q[0][7:0];
        5'h02: cfg_rdata_o <= chan_q[0][15:8];
        5'h04: cfg_rdata_o <= chan_q[1][7:0];
        5'h08: cfg_rdata_o <= chan_q[1][15:8];
        5'h10: cfg_rdata_o <= slave_q;
        default: cfg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ready pins come straight off the cable
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdy_meta_q <= 2'h0;
      rdy_sync_q <= 2'h0;
    end else begin
      rdy_meta_q <= iordy_i;
      rdy_sync_q <= rdy_meta_q;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      wire [15:0] tim;
      wire d1;
      wire fast;
      wire fast0;
      wire fast1;
      wire use_slave;
      wire [1:0] slv_isp;
      wire [1:0] slv_rct;
      wire [1:0] isp_code;
      wire [1:0] rct_code;
      wire [2:0] sample;
      wire [2:0] recov;
      wire rdy_en;
      wire post;

      assign tim = chan_q[c];
      assign d1 = acc_drive1_i[c];
      assign slv_isp = slv_field(slave_q, c == 1, 1'h1);
      assign slv_rct = slv_field(slave_q, c == 1, 1'h0);
      assign fast0 = fast_sel(tim[`IPTS_F_FAST0], tim[`IPTS_F_DMA0],
        acc_dma_i[c]);
      assign fast1 = fast_sel(tim[`IPTS_F_FAST1], tim[`IPTS_F_DMA1],
        acc_dma_i[c]);
      assign fast = d1 ? fast1 : fast0;
      assign use_slave = d1 & tim[`IPTS_F_SEPSEL];
      assign isp_code = use_slave ? slv_isp :
        tim[`IPTS_F_ISP_LO +: 2];
      assign rct_code = use_slave ? slv_rct :
        tim[`IPTS_F_RCT_LO +: 2];
      assign sample = fast ? isp_clks(isp_code) :
        `IPTS_COMPAT_ISP;
      assign recov = fast ? rct_clks(rct_code) :
        `IPTS_COMPAT_RCT;
      assign rdy_en = d1 ? tim[`IPTS_F_RDY1] : tim[`IPTS_F_RDY0];
      assign post = d1 ? tim[`IPTS_F_POST1] : tim[`IPTS_F_POST0];

      ipts_engine u_eng (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .req_i(acc_req_i[c]),
        .write_i(acc_write_i[c]),
        .sample_i(sample),
        .recov_i(recov),
        .ready_en_i(rdy_en),
        .post_i(post),
        .iordy_i(rdy_sync_q[c]),
        .rd_n_o(dior_n_o[c]),
        .wr_n_o(diow_n_o[c]),
        .ack_o(acc_ack_o[c]),
        .prefetch_o(prefetch_o[c]),
        .busy_o(acc_busy_o[c])
      );
    end
  endgenerate

endmodule

`default_nettype wire

/* File: sim/ipts_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipts_drive_model (
  input wire logic clk_i, // clock
  input wire logic [1:0] strobe_n_i, // both strobes anded
  input wire logic [1:0] stall_i, // hold ready low on next strobe
  output wire logic [1:0] iordy_o // ready, pulled up when idle
);
  logic [1:0] last_q = 2'h3;
  int cnt_q [2] = '{0, 0};
  // a slow drive holds ready low well past the largest sample point
  always @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (last_q[c] && !strobe_n_i[c] && stall_i[c]) cnt_q[c] <= 10;
      else if (cnt_q[c] > 0) cnt_q[c] <= cnt_q[c] - 1;
    end
    last_q <= strobe_n_i;
  end
  assign iordy_o = {cnt_q[1] == 0, cnt_q[0] == 0};
endmodule
`default_nettype wire

/* File: sim/ipts_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ipts_top_sva (
  input wire logic clk_i, // clock
  input wire logic srst_i, // reset
  input wire logic [7:0] cfg_rdata_o, // read data
  input wire logic [1:0] dior_n_o, // read strobes
  input wire logic [1:0] diow_n_o, // write strobes
  input wire logic [1:0] acc_ack_o, // done pulses
  input wire logic [1:0] acc_busy_o // busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  rst_idle_a: assert property ($fell(srst_i) |-> &dior_n_o && &diow_n_o
    && acc_busy_o == 2'h0 && cfg_rdata_o == 8'h00) else $error("not idle");
  rd_min_a: assert property ($fell(dior_n_o[0]) |-> !dior_n_o[0] [*3])
    else $error("read strobe short");
  wr_min_a: assert property ($fell(diow_n_o[1]) |-> !diow_n_o[1] [*3])
    else $error("write strobe short");
  ack_rise_a: assert property ($rose(dior_n_o[0]) |-> acc_ack_o[0])
    else $error("no ack at strobe end");
  strobe_gap_a: assert property ($rose(dior_n_o[0]) |->
    (dior_n_o[0] && diow_n_o[0]) [*2]) else $error("recovery short");
  one_strobe_a: assert property ((dior_n_o | diow_n_o) == 2'h3)
    else $error("both strobes low");
  busy_cov_a: assert property (!diow_n_o[1] |-> acc_busy_o[1])
    else $error("strobe while idle");
  ack_one_a: assert property (acc_ack_o[1] |=> !acc_ack_o[1])
    else $error("ack too long");
  recov_busy_a: assert property ($rose(diow_n_o[1]) |-> acc_busy_o[1])
    else $error("no recovery");
  cover property ($rose(dior_n_o[0]));
  cover property ($rose(diow_n_o[1]));
  cover property (acc_ack_o[1] && !diow_n_o[1]);
endmodule
`default_nettype wire

/* File: sim/test_ipts_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ipts_top;
  logic clk_i = 1'h0, srst_i = 1'h1, cfg_wr_i = 1'h0, cfg_rd_i = 1'h0;
  logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, slv;
  logic [1:0] acc_req_i = 2'h0, acc_drive1_i = 2'h0, acc_dma_i = 2'h0;
  logic [1:0] acc_write_i = 2'h0, iordy_i, dior_n_o, diow_n_o, stall = 2'h0;
  logic [1:0] acc_ack_o, acc_busy_o, prefetch_o;
  logic [15:0] chn [2];
  logic [31:0] seed = 32'h3F;
  int fail_count = 0, total_checks = 0;
  always #50 clk_i = ~clk_i;
  ipts_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .acc_req_i(acc_req_i),
    .acc_drive1_i(acc_drive1_i), .acc_dma_i(acc_dma_i),
    .acc_write_i(acc_write_i), .iordy_i(iordy_i), .dior_n_o(dior_n_o),
    .diow_n_o(diow_n_o), .acc_ack_o(acc_ack_o), .acc_busy_o(acc_busy_o),
    .prefetch_o(prefetch_o));
  ipts_drive_model i_drv (.clk_i(clk_i), .strobe_n_i(dior_n_o & diow_n_o),
    .stall_i(stall), .iordy_o(iordy_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] exp_t(logic c, logic d1, logic dma);
    logic [15:0] t;
    logic [1:0] sp, rc;
    logic f;
    t = chn[c];
    f = d1 ? (dma ? t[4] | t[7] : t[4] & ~t[7])
      : (dma ? t[0] | t[3] : t[0] & ~t[3]);
    sp = t[13:12];
    rc = t[9:8];
    if (d1 && t[14]) begin
      sp = c ? slv[7:6] : slv[3:2];
      rc = c ? slv[5:4] : slv[1:0];
    end
    if (!f) return 6'h3F;
    return {(sp == 2'h0) ? 3'h5 : (sp == 2'h1) ? 3'h4 : 3'h3, 3'h4 - rc};
  endfunction
  task automatic chk(logic ok, string m);
    total_checks++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cw(logic [7:0] a, logic [7:0] d);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'h1;
    @(posedge clk_i) #1 cfg_wr_i = 1'h0;
    @(posedge clk_i) #1;
  endtask
  task automatic cr(logic [7:0] a, output logic [7:0] d);
    cfg_addr_i = a;
    cfg_rd_i = 1'h1;
    @(posedge clk_i) #1 cfg_rd_i = 1'h0;
    @(posedge clk_i) #1 d = cfg_rdata_o;
  endtask
  task automatic wch(logic c, logic [15:0] v);
    cw({6'h10, c, 1'h0}, v[7:0]);
    cw({6'h10, c, 1'h1}, v[15:8]);
    chn[c] = v;
  endtask
  task automatic acc(logic c, logic d1, logic dma, logic w,
    output int s, output int r, output logic a);
    acc_req_i[c] = 1'h1;
    acc_drive1_i[c] = d1;
    acc_dma_i[c] = dma;
    acc_write_i[c] = w;
    @(posedge clk_i) #1 acc_req_i[c] = 1'h0;
    a = acc_ack_o[c];
    s = 0;
    r = 0;
    repeat (3) if (dior_n_o[c] & diow_n_o[c]) @(posedge clk_i) #1;
    while (!(dior_n_o[c] & diow_n_o[c]) && s < 60) @(posedge clk_i) #1 s++;
    while (acc_busy_o[c] !== 1'h0 && r < 60) @(posedge clk_i) #1 r++;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    logic [15:0] cv [4];
    logic [15:0] v;
    logic [31:0] x;
    logic [7:0] d;
    logic [5:0] e;
    logic pk;
    int s, r;
    cv = '{16'h0009, 16'h3301, 16'h6210, 16'h4090};
    repeat (3) @(posedge clk_i);
    #1 srst_i = 1'h0;
    for (int a = 0; a < 6; a++) begin
      cr(8'h40 + 8'(a), d);
      chk(d === 8'h00, "reset value");
    end
    x = rnd();
    cw(8'h44, x[7:0]);
    slv = x[7:0];
    cr(8'h44, d);
    chk(d === slv, "slave readback");
    cw(8'h41, 8'hFF);
    cr(8'h41, d);
    chk(d === 8'hF3, "reserved bits read zero");
    $display("register test done");
    for (int i = 0; i < 40; i++) begin
      v = (i < 4) ? cv[i] : 16'(rnd());
      wch(i[0], v);
      x = rnd();
      cw(8'h44, x[15:8]);
      slv = x[15:8];
      acc(i[0], i[1], x[0], x[1], s, r, pk);
      e = exp_t(i[0], i[1], x[0]);
      chk(pk === (x[1] & v[i[1] ? 6 : 2]), "posted ack");
      chk(s == e[5:3] && r == e[2:0], "access timing");
      if (!x[1] && !x[0])
        chk(prefetch_o[i[0]] === v[i[1] ? 6 : 2], "prefetch flag");
    end
    $display("timing test done");
    stall = 2'h1;
    for (int k = 0; k < 2; k++) begin
      wch(1'h0, k[0] ? 16'h0002 : 16'h0000);
      acc(1'h0, 1'h0, 1'h0, 1'h0, s, r, pk);
      chk((s > 7) == k[0], "ready sampling");
    end
    $display("ready test done");
    summarize();
  end
endmodule
bind ipts_top ipts_top_sva i_sva (.clk_i(clk_i), .srst_i(srst_i),
  .cfg_rdata_o(cfg_rdata_o), .dior_n_o(dior_n_o), .diow_n_o(diow_n_o),
  .acc_ack_o(acc_ack_o), .acc_busy_o(acc_busy_o));
`default_nettype wire
